// ===== dv/dlm_top_assertions.sv
// Port checks of the drive limit monitor
`timescale 1ns/1ns
module dlm_top_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic run_cmd,
    input wire logic [15:0] out_current,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] ref_freq,
    input wire logic [15:0] current_cap,
    input wire logic [15:0] torque_scale,
    input wire logic [5:0] warn_flags,
    input wire logic signal_out,
    input wire logic relay_out
);
    // ****
    // Helper state
    // ****
    logic armed_reg, armed_next, wr_reg, wr_next;

    // Loose arming view and write data phase
    always_comb
    begin
        armed_next = run_cmd && (armed_reg || out_freq == ref_freq);
        wr_next = hsel && hready && htrans[1] && hwrite;
    end

    // Helper registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            armed_reg <= 1'b0;
            wr_reg <= 1'b0;
        end
        else
        begin
            armed_reg <= armed_next;
            wr_reg <= wr_next;
        end
    end

    // ****
    // Properties
    // ****
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_stop_two;
        !run_cmd ##1 !run_cmd;
    endsequence
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    property p_cap_by_write;
        $changed(current_cap) |-> $past(wr_reg);
    endproperty
    property p_torque;
        $stable(current_cap) |-> torque_scale == ((current_cap < 16'h03E8) ? current_cap : 16'h03E8);
    endproperty
    property p_stop_quiet;
        s_stop_two |=> warn_flags == 6'h00 && !signal_out && !relay_out;
    endproperty
    property p_armed_only;
        warn_flags != 6'h00 |-> $past(armed_reg && run_cmd);
    endproperty
    property p_route_quiet;
        $past(warn_flags) == 6'h00 |-> !signal_out && !relay_out;
    endproperty
    property p_freq_high;
        warn_flags[3] |-> $past(out_freq) != 16'h0000;
    endproperty
    property p_cur_high;
        warn_flags[1] |-> $past(out_current) != 16'h0000;
    endproperty

    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not OKAY");
    a_cap_by_write: assert property (p_cap_by_write)
        else $error("cap changed without write");
    a_torque: assert property (p_torque)
        else $error("torque not following cap");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("warning while stopped");
    a_armed_only: assert property (p_armed_only)
        else $error("warning before arming");
    a_route_quiet: assert property (p_route_quiet)
        else $error("routed output without warning");
    a_freq_high: assert property (p_freq_high)
        else $error("high frequency warning at zero");
    a_cur_high: assert property (p_cur_high)
        else $error("high current warning at zero");
endmodule

bind dlm_top dlm_top_assertions u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .run_cmd(run_cmd),
    .out_current(out_current), .out_freq(out_freq), .ref_freq(ref_freq),
    .current_cap(current_cap), .torque_scale(torque_scale), .warn_flags(warn_flags),
    .signal_out(signal_out), .relay_out(relay_out)
);

// ===== dv/test_drive_limit_monitor.sv
// Testbench of the drive limit monitor
`timescale 1ns/1ns
module test_drive_limit_monitor;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run_cmd;
    logic signal_out, relay_out, exp_s, exp_r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] warn_flags, exp_w;
    logic [15:0] out_current, out_freq, ref_freq, freq_request, current_cap;
    logic [15:0] torque_scale, freq_target, f;
    logic [31:0] haddr, hwdata, hrdata, feedback, seed, rd, r;
    logic [31:0] mdl [0:15];
    int num_errors, samples_checked, cycles, ph;

    dlm_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .run_cmd(run_cmd),
        .out_current(out_current), .out_freq(out_freq), .ref_freq(ref_freq),
        .feedback(feedback), .freq_request(freq_request), .current_cap(current_cap),
        .torque_scale(torque_scale), .freq_target(freq_target), .warn_flags(warn_flags),
        .signal_out(signal_out), .relay_out(relay_out)
    );

    // ****
    // Models
    // ****
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Register image after reset
    task automatic mdl_reset();
        for (int i = 0; i < 16; i++)
            mdl[i] = 32'h00000000;
        mdl[1] = 32'h00000640;
        mdl[3] = 32'h0000FFFF;
        mdl[5] = 32'h00000528;
        mdl[6] = 32'hFFC2F700;
        mdl[7] = 32'h003D0900;
    endtask

    function automatic logic [31:0] mdl_wr(input logic [7:0] a, input logic [31:0] d);
        logic [15:0] top;
        top = mdl[0][0] ? 16'h2710 : 16'h0528;
        case (a)
            dlm_pkg::ADDR_CTRL: return {31'h0, d[0]};
            dlm_pkg::ADDR_FRQ_HIGH: return {16'h0, (d[15:0] > top) ? top : d[15:0]};
            dlm_pkg::ADDR_BYP_BW: return {16'h0, (d[15:0] > 16'h03E8) ? 16'h03E8 : d[15:0]};
            dlm_pkg::ADDR_SKIP_A, dlm_pkg::ADDR_SKIP_B:
                return {16'h0, (d[15:0] > 16'h2710) ? 16'h2710 : d[15:0]};
            dlm_pkg::ADDR_LOW_FEEDBACK_LIMIT, dlm_pkg::ADDR_HIGH_FEEDBACK_LIMIT: return d;
            dlm_pkg::ADDR_ROUTE: return {18'h0, d[13:8], 2'h0, d[5:0]};
            dlm_pkg::ADDR_STATUS, dlm_pkg::ADDR_TORQUE, 8'h38: return mdl[a[5:2]];
            default: return {16'h0, d[15:0]};
        endcase
    endfunction

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        if (a == dlm_pkg::ADDR_TORQUE)
            return (mdl[1] < 32'h000003E8) ? mdl[1] : 32'h000003E8;
        return mdl[a[5:2]];
    endfunction

    function automatic logic [5:0] cond();
        logic [5:0] c;
        c[0] = out_current < mdl[2][15:0];
        c[1] = out_current > mdl[3][15:0];
        c[2] = out_freq < mdl[4][15:0];
        c[3] = out_freq > mdl[5][15:0];
        c[4] = $signed(feedback) < $signed(mdl[6]);
        c[5] = $signed(feedback) > $signed(mdl[7]);
        return c;
    endfunction

    function automatic logic [15:0] skip_exp(input logic [15:0] q);
        logic [15:0] h, c;
        h = mdl[8][15:0] >> 1;
        for (int i = 9; i < 11; i++)
        begin
            c = mdl[i][15:0];
            if (q > c - h && q < c + h)
                return (q < c) ? c - h : c + h;
        end
        return q;
    endfunction

    // ****
    // Tasks
    // ****
    task automatic cmp(input string what, input logic [31:0] expv, input logic [31:0] got);
        samples_checked++;
        if (got !== expv)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, expv, got);
        end
    endtask

    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
        if (wr)
            mdl[a[5:2]] <= mdl_wr(a, wd);
    endtask

    task automatic check_regs(input string name);
        for (int a = 0; a <= 8'h38; a += 4)
        begin
            bus(1'b0, a[7:0], 32'h00000000);
            cmp("register read", exp_rd(a[7:0]), rd);
        end
        cmp("current_cap", {16'h0, mdl[1][15:0]}, {16'h0, current_cap});
        cmp("torque_scale", exp_rd(dlm_pkg::ADDR_TORQUE), {16'h0, torque_scale});
        $display("Test %s done", name);
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Clock and watchdog
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            final_report();
        end
    end

    // Arming, warning and routing model, checked each edge
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph = 0;
            exp_w = 6'h00;
            exp_s = 1'b0;
            exp_r = 1'b0;
        end
        else
        begin
            cmp("warn_flags", {26'h0, exp_w}, {26'h0, warn_flags});
            cmp("signal_out", {31'h0, exp_s}, {31'h0, signal_out});
            cmp("relay_out", {31'h0, exp_r}, {31'h0, relay_out});
            exp_s = |(exp_w & mdl[11][5:0]);
            exp_r = |(exp_w & mdl[11][13:8]);
            exp_w = (ph == 2 && run_cmd) ? cond() : 6'h00;
            if (!run_cmd)
                ph = 0;
            else if (ph == 0)
                ph = 1;
            else if (out_freq == ref_freq)
                ph = 2;
        end
    end

    // ****
    // Sequence
    // ****
    initial
    begin
        seed = 32'h0000F4F0;
        {hresetn, hsel, hwrite, run_cmd} = 4'h0;
        {haddr, hwdata, feedback} = 96'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        {out_current, out_freq, freq_request} = 48'h0;
        ref_freq = 16'h0200;
        mdl_reset();
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        check_regs("reset values");
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, dlm_pkg::ADDR_CTRL, {31'h0, k[0]});
            for (int a = 4; a <= 8'h38; a += 4)
                bus(1'b1, a[7:0], rnd());
            check_regs("register writes");
        end
        for (int a = 8; a < 8'h18; a += 4)
            bus(1'b1, a[7:0], a[2] ? 32'h00000300 : 32'h00000100);
        bus(1'b1, dlm_pkg::ADDR_LOW_FEEDBACK_LIMIT, 32'hFFFF0000);
        bus(1'b1, dlm_pkg::ADDR_HIGH_FEEDBACK_LIMIT, 32'h00010000);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, dlm_pkg::ADDR_ROUTE, rnd());
            for (int j = 0; j < 100; j++)
            begin
                @(posedge hclk);
                r = rnd();
                out_current <= {6'h00, r[9:0]};
                feedback <= {{14{r[17]}}, r[17:0]};
                out_freq <= (j < 20) ? 16'h0000 : (j == 20) ? 16'h0200 : {6'h00, r[29:20]};
                run_cmd <= (j < 90);
            end
        end
        $display("Test warnings done");
        @(posedge hclk);
        run_cmd <= 1'b1;
        out_freq <= 16'h0200;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b0;
        run_cmd <= 1'b0;
        mdl_reset();
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        check_regs("reset in run");
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, dlm_pkg::ADDR_BYP_BW, k ? 32'h000000C8 : 32'h00000000);
            bus(1'b1, dlm_pkg::ADDR_SKIP_A, 32'h000003E8);
            bus(1'b1, dlm_pkg::ADDR_SKIP_B, 32'h00000410);
            for (int j = 0; j < 40; j++)
            begin
                r = rnd();
                f = 16'h0380 + {8'h00, r[7:0]};
                @(posedge hclk);
                freq_request <= f;
                repeat (2) @(posedge hclk);
                cmp("freq_target", {16'h0, skip_exp(f)}, {16'h0, freq_target});
            end
        end
        $display("Test bypass done");
        final_report();
    end
endmodule

// ===== verilog/dlm_compare.sv
// Registered limit comparator gated by arming
`timescale 1ns/1ns
module dlm_compare #(
    parameter int W = 16,
    parameter bit SIGNED = 1'b0,
    parameter bit ABOVE = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic armed,
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] limit,
    output logic warn
);

    logic warn_reg;
    logic warn_next;
    logic hit;

    // Strict compare, signed or unsigned, above or below the limit
    always_comb
    begin
        if (SIGNED)
        begin
            hit = ABOVE ? ($signed(value) > $signed(limit)) : ($signed(value) < $signed(limit));
        end
        else
        begin
            hit = ABOVE ? (value > limit) : (value < limit);
        end
        warn_next = armed && hit;
    end

    // Level flag, falls on the clock edge after the cause goes away
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            warn_reg <= 1'b0;
        end
        else
        begin
            warn_reg <= warn_next;
        end
    end

    assign warn = warn_reg;

endmodule

// ===== verilog/dlm_pkg.sv
// Constants and encodings of the drive limit monitor
//
// Functional notes
// - Current cap in percent of rated, default 160.
// - Cap below rated current scales acceleration torque down alike.
// - Warn when current below low limit, default zero.
// - Warn when current above high limit.
// - Warn when frequency below low limit, default zero.
// - Warn above high frequency limit, default 132 Hz, bound 132 or 1000 Hz.
// - Warn when feedback below low limit, default minus 4000.
// - Warn when feedback above high limit, default 4000.
// - Warnings suppressed in ramp-up, after stop command and while stopped.
// - Warnings arm once output frequency reaches the resulting reference.
// - Each warning routable to signal output and relay.
// - Bypass bandwidth 0 to 100 Hz, default zero; zero disables.
// - Band centred on two skip frequencies, 0 to 1000 Hz, avoided. Code checks band A first; its edge can lie in band B.
package dlm_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CUR_CAP = 8'h04;
    localparam logic [7:0] ADDR_CUR_LOW = 8'h08;
    localparam logic [7:0] ADDR_CUR_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_FRQ_LOW = 8'h10;
    localparam logic [7:0] ADDR_FRQ_HIGH = 8'h14;
    localparam logic [7:0] ADDR_LOW_FEEDBACK_LIMIT = 8'h18;
    localparam logic [7:0] ADDR_HIGH_FEEDBACK_LIMIT = 8'h1C;
    localparam logic [7:0] ADDR_BYP_BW = 8'h20;
    localparam logic [7:0] ADDR_SKIP_A = 8'h24;
    localparam logic [7:0] ADDR_SKIP_B = 8'h28;
    localparam logic [7:0] ADDR_ROUTE = 8'h2C;
    localparam logic [7:0] ADDR_STATUS = 8'h30;
    localparam logic [7:0] ADDR_TORQUE = 8'h34;

    // ****************************************
    // Field layout and widths
    // ****************************************
    localparam int NUM_WARN = 6;
    localparam int CTRL_RANGE_BIT = 0;   // 1 selects the 1000 Hz frequency range
    localparam int ROUTE_RELAY_LSB = 8;  // Relay route mask sits above signal mask
    localparam int STAT_ARMED_BIT = 6;
    localparam int STAT_SIG_BIT = 7;
    localparam int STAT_RELAY_BIT = 8;
    localparam int STAT_STATE_LSB = 9;
    localparam int PCT_W = 16;           // Percent in tenths
    localparam int FRQ_W = 16;           // Hertz in tenths
    localparam int CUR_W = 16;           // Amperes in tenths
    localparam int FB_W = 32;            // Signed feedback in thousandths
    localparam int TQ_W = 16;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [PCT_W-1:0] CUR_CAP_RST = 16'h0640;   // 160.0 percent
    localparam logic [PCT_W-1:0] PCT_FULL = 16'h03E8;      // 100.0 percent, rated
    localparam logic [CUR_W-1:0] CUR_LOW_RST = 16'h0000;
    localparam logic [CUR_W-1:0] CUR_HIGH_RST = 16'hFFFF;
    localparam logic [FRQ_W-1:0] FRQ_LOW_RST = 16'h0000;
    localparam logic [FRQ_W-1:0] FRQ_HIGH_RST = 16'h0528;  // 132.0 Hz
    localparam logic [FRQ_W-1:0] FRQ_MAX_LO = 16'h0528;    // 132.0 Hz bound
    localparam logic [FRQ_W-1:0] FRQ_MAX_HI = 16'h2710;    // 1000.0 Hz bound
    localparam logic [FRQ_W-1:0] BYP_BW_MAX = 16'h03E8;    // 100.0 Hz
    localparam logic [FRQ_W-1:0] SKIP_RST = 16'h0000;
    localparam logic [FB_W-1:0] LOW_FEEDBACK_LIMIT_RST = 32'hFFC2F700; // -4000.000
    localparam logic [FB_W-1:0] HIGH_FEEDBACK_LIMIT_RST = 32'h003D0900; // 4000.000
    localparam logic [NUM_WARN-1:0] ROUTE_RST = 6'h00;

    // ****************************************
    // Warning bit positions
    // ****************************************
    localparam int W_CUR_LOW = 0;
    localparam int W_CUR_HIGH = 1;
    localparam int W_FRQ_LOW = 2;
    localparam int W_FRQ_HIGH = 3;
    localparam int W_LOW_FEEDBACK_LIMIT = 4;
    localparam int W_HIGH_FEEDBACK_LIMIT = 5;

    // Drive run phase as seen by the arming logic
    typedef enum logic [1:0] {DLM_STOPPED, DLM_RAMPING, DLM_ARMED} dlm_phase_t;

endpackage

// ===== verilog/dlm_top.sv
// Drive limit monitor: registers, warnings, current cap and bypass
`timescale 1ns/1ns
module dlm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic run_cmd,
    input wire logic [15:0] out_current,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] ref_freq,
    input wire logic [31:0] feedback,
    input wire logic [15:0] freq_request,
    output logic [15:0] current_cap,
    output logic [15:0] torque_scale,
    output logic [15:0] freq_target,
    output logic [5:0] warn_flags,
    output logic signal_out,
    output logic relay_out
);

    // ****************************************
    // Register file
    // ****************************************
    logic ctrl_reg, ctrl_next;
    logic [15:0] cap_reg, cap_next;
    logic [15:0] clow_reg, clow_next;
    logic [15:0] chigh_reg, chigh_next;
    logic [15:0] flow_reg, flow_next;
    logic [15:0] fhigh_reg, fhigh_next;
    logic [31:0] fblow_reg, fblow_next;
    logic [31:0] fbhigh_reg, fbhigh_next;
    logic [15:0] bw_reg, bw_next;
    logic [15:0] skipa_reg, skipa_next;
    logic [15:0] skipb_reg, skipb_next;
    logic [11:0] route_reg, route_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [15:0] fmax;
    logic [15:0] wdata16;
    logic access;
    logic [7:0] ra;

    assign access = hsel && hready && htrans[1];
    assign ra = haddr[7:0];
    assign wdata16 = hwdata[15:0];
    assign fmax = ctrl_reg ? dlm_pkg::FRQ_MAX_HI : dlm_pkg::FRQ_MAX_LO;

    // ****************************************
    // Drive phase and outputs
    // ****************************************
    dlm_pkg::dlm_phase_t phase_reg, phase_next;
    logic [5:0] warn_raw;
    logic armed;
    logic sig_reg, sig_next, relay_reg, relay_next;
    logic [15:0] tq_reg, tq_next;
    logic [15:0] tgt_reg, tgt_next;
    logic [15:0] band_lo_a, band_hi_a, band_lo_b, band_hi_b;

    // Bus writes land one cycle after the address phase; high frequency, bypass and skip writes clamped
    always_comb
    begin
        ctrl_next = ctrl_reg;
        cap_next = cap_reg;
        clow_next = clow_reg;
        chigh_next = chigh_reg;
        flow_next = flow_reg;
        fhigh_next = fhigh_reg;
        fblow_next = fblow_reg;
        fbhigh_next = fbhigh_reg;
        bw_next = bw_reg;
        skipa_next = skipa_reg;
        skipb_next = skipb_reg;
        route_next = route_reg;
        wr_pend_next = access && hwrite;
        wr_addr_next = access ? haddr[7:0] : wr_addr_reg;
        if (wr_pend_reg)
        begin
            if (wr_addr_reg == dlm_pkg::ADDR_CTRL)
                ctrl_next = hwdata[dlm_pkg::CTRL_RANGE_BIT];
            else if (wr_addr_reg == dlm_pkg::ADDR_CUR_CAP)
                cap_next = wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_CUR_LOW)
                clow_next = wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_CUR_HIGH)
                chigh_next = wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_FRQ_LOW)
                flow_next = wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_FRQ_HIGH)
                fhigh_next = (wdata16 > fmax) ? fmax : wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_LOW_FEEDBACK_LIMIT)
                fblow_next = hwdata;
            else if (wr_addr_reg == dlm_pkg::ADDR_HIGH_FEEDBACK_LIMIT)
                fbhigh_next = hwdata;
            else if (wr_addr_reg == dlm_pkg::ADDR_BYP_BW)
                bw_next = (wdata16 > dlm_pkg::BYP_BW_MAX) ? dlm_pkg::BYP_BW_MAX : wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_SKIP_A)
                skipa_next = (wdata16 > dlm_pkg::FRQ_MAX_HI) ? dlm_pkg::FRQ_MAX_HI : wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_SKIP_B)
                skipb_next = (wdata16 > dlm_pkg::FRQ_MAX_HI) ? dlm_pkg::FRQ_MAX_HI : wdata16;
            else if (wr_addr_reg == dlm_pkg::ADDR_ROUTE)
                route_next = {hwdata[dlm_pkg::ROUTE_RELAY_LSB +: 6], hwdata[5:0]};
        end
    end

    // Read data chosen in the address phase, unmapped reads return zero
    always_comb
    begin
        rdata_next = rdata_reg;
        if (access && !hwrite)
        begin
            rdata_next = 32'h00000000;
            if (ra == dlm_pkg::ADDR_CTRL)
                rdata_next[0] = ctrl_reg;
            else if (ra == dlm_pkg::ADDR_CUR_CAP)
                rdata_next[15:0] = cap_reg;
            else if (ra == dlm_pkg::ADDR_CUR_LOW)
                rdata_next[15:0] = clow_reg;
            else if (ra == dlm_pkg::ADDR_CUR_HIGH)
                rdata_next[15:0] = chigh_reg;
            else if (ra == dlm_pkg::ADDR_FRQ_LOW)
                rdata_next[15:0] = flow_reg;
            else if (ra == dlm_pkg::ADDR_FRQ_HIGH)
                rdata_next[15:0] = fhigh_reg;
            else if (ra == dlm_pkg::ADDR_LOW_FEEDBACK_LIMIT)
                rdata_next = fblow_reg;
            else if (ra == dlm_pkg::ADDR_HIGH_FEEDBACK_LIMIT)
                rdata_next = fbhigh_reg;
            else if (ra == dlm_pkg::ADDR_BYP_BW)
                rdata_next[15:0] = bw_reg;
            else if (ra == dlm_pkg::ADDR_SKIP_A)
                rdata_next[15:0] = skipa_reg;
            else if (ra == dlm_pkg::ADDR_SKIP_B)
                rdata_next[15:0] = skipb_reg;
            else if (ra == dlm_pkg::ADDR_ROUTE)
                rdata_next = {18'h00000, route_reg[11:6], 2'h0, route_reg[5:0]};
            else if (ra == dlm_pkg::ADDR_STATUS)
                rdata_next[10:0] = {phase_reg, relay_reg, sig_reg, armed, warn_raw};
            else if (ra == dlm_pkg::ADDR_TORQUE)
                rdata_next[15:0] = tq_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= 1'b0;
            cap_reg <= dlm_pkg::CUR_CAP_RST;
            clow_reg <= dlm_pkg::CUR_LOW_RST;
            chigh_reg <= dlm_pkg::CUR_HIGH_RST;
            flow_reg <= dlm_pkg::FRQ_LOW_RST;
            fhigh_reg <= dlm_pkg::FRQ_HIGH_RST;
            fblow_reg <= dlm_pkg::LOW_FEEDBACK_LIMIT_RST;
            fbhigh_reg <= dlm_pkg::HIGH_FEEDBACK_LIMIT_RST;
            bw_reg <= 16'h0000;
            skipa_reg <= dlm_pkg::SKIP_RST;
            skipb_reg <= dlm_pkg::SKIP_RST;
            route_reg <= {dlm_pkg::ROUTE_RST, dlm_pkg::ROUTE_RST};
            rdata_reg <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            cap_reg <= cap_next;
            clow_reg <= clow_next;
            chigh_reg <= chigh_next;
            flow_reg <= flow_next;
            fhigh_reg <= fhigh_next;
            fblow_reg <= fblow_next;
            fbhigh_reg <= fbhigh_next;
            bw_reg <= bw_next;
            skipa_reg <= skipa_next;
            skipb_reg <= skipb_next;
            route_reg <= route_next;
            rdata_reg <= rdata_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    // ****************************************
    // Arming: stopped, ramping, armed
    // ****************************************
    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            dlm_pkg::DLM_STOPPED:
                if (run_cmd)
                    phase_next = dlm_pkg::DLM_RAMPING;
            dlm_pkg::DLM_RAMPING:
                if (!run_cmd)
                    phase_next = dlm_pkg::DLM_STOPPED;
                else if (out_freq == ref_freq)
                    phase_next = dlm_pkg::DLM_ARMED;
            dlm_pkg::DLM_ARMED:
                if (!run_cmd)
                    phase_next = dlm_pkg::DLM_STOPPED;
            default:
                phase_next = dlm_pkg::DLM_STOPPED;
        endcase
    end

    assign armed = (phase_reg == dlm_pkg::DLM_ARMED) && run_cmd;

    // ****************************************
    // Six limit comparators
    // ****************************************
    dlm_compare #(.W(16), .SIGNED(1'b0), .ABOVE(1'b0)) u_cur_low (
        .hclk(hclk), .hresetn(hresetn), .armed(armed),
        .value(out_current), .limit(clow_reg), .warn(warn_raw[dlm_pkg::W_CUR_LOW]));
    dlm_compare #(.W(16), .SIGNED(1'b0), .ABOVE(1'b1)) u_cur_high (
        .hclk(hclk), .hresetn(hresetn), .armed(armed),
        .value(out_current), .limit(chigh_reg), .warn(warn_raw[dlm_pkg::W_CUR_HIGH]));
    dlm_compare #(.W(16), .SIGNED(1'b0), .ABOVE(1'b0)) u_frq_low (
        .hclk(hclk), .hresetn(hresetn), .armed(armed),
        .value(out_freq), .limit(flow_reg), .warn(warn_raw[dlm_pkg::W_FRQ_LOW]));
    dlm_compare #(.W(16), .SIGNED(1'b0), .ABOVE(1'b1)) u_frq_high (
        .hclk(hclk), .hresetn(hresetn), .armed(armed),
        .value(out_freq), .limit(fhigh_reg), .warn(warn_raw[dlm_pkg::W_FRQ_HIGH]));
    dlm_compare #(.W(32), .SIGNED(1'b1), .ABOVE(1'b0)) u_low_feedback_limit (
        .hclk(hclk), .hresetn(hresetn), .armed(armed),
        .value(feedback), .limit(fblow_reg), .warn(warn_raw[dlm_pkg::W_LOW_FEEDBACK_LIMIT]));
    dlm_compare #(.W(32), .SIGNED(1'b1), .ABOVE(1'b1)) u_high_feedback_limit (
        .hclk(hclk), .hresetn(hresetn), .armed(armed),
        .value(feedback), .limit(fbhigh_reg), .warn(warn_raw[dlm_pkg::W_HIGH_FEEDBACK_LIMIT]));

    // ****************************************
    // Routing, torque scale and bypass
    // ****************************************
    assign band_lo_a = (skipa_reg > (bw_reg >> 1)) ? skipa_reg - (bw_reg >> 1) : 16'h0000;
    assign band_hi_a = skipa_reg + (bw_reg >> 1);
    assign band_lo_b = (skipb_reg > (bw_reg >> 1)) ? skipb_reg - (bw_reg >> 1) : 16'h0000;
    assign band_hi_b = skipb_reg + (bw_reg >> 1);

    always_comb
    begin
        sig_next = |(warn_raw & route_reg[5:0]);
        relay_next = |(warn_raw & route_reg[11:6]);
        tq_next = (cap_reg < dlm_pkg::PCT_FULL) ? cap_reg : dlm_pkg::PCT_FULL;
        tgt_next = freq_request;
        if (bw_reg != 16'h0000)
        begin
            // Snap to the nearer edge of the first band holding the request, A before B; an edge of band A can lie inside an overlapping band B
            if (freq_request > band_lo_a && freq_request < band_hi_a)
                tgt_next = (freq_request < skipa_reg) ? band_lo_a : band_hi_a;
            else if (freq_request > band_lo_b && freq_request < band_hi_b)
                tgt_next = (freq_request < skipb_reg) ? band_lo_b : band_hi_b;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_reg <= dlm_pkg::DLM_STOPPED;
            sig_reg <= 1'b0;
            relay_reg <= 1'b0;
            tq_reg <= dlm_pkg::PCT_FULL;
            tgt_reg <= 16'h0000;
        end
        else
        begin
            phase_reg <= phase_next;
            sig_reg <= sig_next;
            relay_reg <= relay_next;
            tq_reg <= tq_next;
            tgt_reg <= tgt_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign current_cap = cap_reg;
    assign torque_scale = tq_reg;
    assign freq_target = tgt_reg;
    assign warn_flags = warn_raw;
    assign signal_out = sig_reg;
    assign relay_out = relay_reg;

endmodule
